/* src/serial_cmd_pkg.sv */
package serial_cmd_pkg;
  // ----------------------------------------
  // byte codes and fields
  // ----------------------------------------
  localparam logic [2:0] ADDR_CODE = 3'h6;
  localparam logic [2:0] DEF_CODE = 3'h7;
  localparam int CODE_MSB = 7;
  localparam int CODE_LSB = 5;
  localparam int CM_BIT = 4;
  localparam int SA_BIT = 3;
  localparam int NUM_PARAMS = 7;
  localparam logic [1:0] FINE_PAGE = 2'h1;
  localparam logic [2:0] FINE_REG = 3'h0;
  localparam logic [2:0] SQL_REG = 3'h1;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS = 50;
  localparam int LOOK_WAIT_NS = 3200;
  localparam int LOOK_WAIT_CYC = LOOK_WAIT_NS / CLK_PERIOD_NS;
  localparam int RSP_WAIT_NS = 20000;
  localparam int RSP_WAIT_CYC = RSP_WAIT_NS / CLK_PERIOD_NS;
  // ----------------------------------------
  // controller register offsets
  // ----------------------------------------
  localparam logic [3:0] REG_TARGET = 4'h0;
  localparam logic [3:0] REG_DEF = 4'h1;
  localparam logic [3:0] REG_TIER = 4'h2;
  localparam logic [3:0] REG_GO = 4'h3;
  localparam logic [3:0] REG_DATA0 = 4'h4;
  localparam logic [3:0] REG_STATUS = 4'hb;
  localparam logic [3:0] REG_CFG = 4'hc;
  localparam int ST_BUSY = 0;
  localparam int ST_DONE = 1;
  localparam int ST_ERR = 2;

  // parity bit for a byte, even or odd sense
  function automatic logic par_bit(input logic [7:0] b, input logic even);
    par_bit = even ? ^b : ~^b;
  endfunction : par_bit
endpackage : serial_cmd_pkg

/* src/serial_link_if.sv */
`timescale 1ns/1ns
interface serial_link_if;
  logic ctl_valid;
  logic [7:0] ctl_byte;
  logic ctl_par;
  logic rsp_valid;
  logic [7:0] rsp_byte;
  logic rsp_par;
  modport device (
    input ctl_valid, ctl_byte, ctl_par,
    output rsp_valid, rsp_byte, rsp_par
  );
  modport controller (
    output ctl_valid, ctl_byte, ctl_par,
    input rsp_valid, rsp_byte, rsp_par
  );
endinterface : serial_link_if

/* src/chain_receiver_end.sv */
`timescale 1ns/1ns
module chain_receiver_end #(
  parameter int NREG = serial_cmd_pkg::NUM_PARAMS
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // link to controller
  serial_link_if.device link,
  // straps and receiver state
  input wire logic [3:0] own_address,
  input wire logic remote_mode,
  input wire logic parity_enable,
  input wire logic parity_even,
  input wire logic fine_fitted,
  input wire logic [3:0] fine_digit,
  input wire logic carrier_squelch_flag,
  input wire logic [3:0] squelch_threshold,
  // parameter bank
  output logic [NREG*8-1:0] param_out,
  output logic param_written,
  // chain output port
  output logic chain_valid,
  output logic [7:0] chain_byte,
  output logic chain_par
);
  typedef enum logic [2:0] {
    S_IDLE, S_DEF, S_LOOK, S_DATA, S_REPLY
  } state_t;

  state_t state_q;
  logic [7:0] def_q;
  logic [7:0] tier_q;
  logic tier_hit_q;
  logic [3:0] cnt_q;
  logic [15:0] wait_q;
  logic [7:0] param_q [NREG];
  logic rx_ok;
  logic rx_bad;
  logic [2:0] rx_code;
  logic is_addr;
  logic own_addr;
  logic single;
  logic [3:0] reply_last;
  logic [7:0] tx_byte;
  logic [7:0] tier_byte;

  // ----------------------------------------
  // receive decode
  // ----------------------------------------
  assign rx_code = link.ctl_byte[serial_cmd_pkg::CODE_MSB:
                                 serial_cmd_pkg::CODE_LSB];
  assign rx_bad = link.ctl_valid && parity_enable &&
    (link.ctl_par != serial_cmd_pkg::par_bit(link.ctl_byte,
                                             parity_even));
  assign rx_ok = link.ctl_valid && !rx_bad;
  assign is_addr = rx_ok && rx_code == serial_cmd_pkg::ADDR_CODE;
  assign own_addr = is_addr &&
    link.ctl_byte[4:0] == {1'b0, own_address};
  assign single = def_q[serial_cmd_pkg::SA_BIT];
  assign reply_last = single ? 4'h1 : 4'(NREG);

  // ----------------------------------------
  // frame sequencer
  // ----------------------------------------
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= S_IDLE;
      def_q <= serial_cmd_pkg::RESET_BYTE;
      tier_q <= serial_cmd_pkg::RESET_BYTE;
      tier_hit_q <= 1'b0;
      cnt_q <= 4'h0;
      wait_q <= 16'h0000;
    end else if (state_q == S_REPLY) begin
      cnt_q <= cnt_q + 4'h1;
      if (cnt_q == reply_last) begin
        state_q <= S_IDLE;
      end
    end else if (rx_bad) begin
      state_q <= S_IDLE;
    end else if (is_addr) begin
      state_q <= own_addr ? S_DEF : S_IDLE;
      tier_hit_q <= 1'b0;
    end else begin
      case (state_q)
        S_DEF: begin
          if (rx_ok) begin
            if (rx_code == serial_cmd_pkg::DEF_CODE) begin
              def_q <= link.ctl_byte;
              cnt_q <= 4'h0;
              wait_q <= 16'h0000;
              state_q <= link.ctl_byte[serial_cmd_pkg::CM_BIT] ?
                         S_DATA : S_LOOK;
            end else begin
              state_q <= S_IDLE;
            end
          end
        end
        S_LOOK: begin
          if (rx_ok) begin
            if (rx_code == serial_cmd_pkg::DEF_CODE && !tier_hit_q) begin
              tier_q <= def_q;
              tier_hit_q <= 1'b1;
              def_q <= link.ctl_byte;
              wait_q <= 16'h0000;
              state_q <= link.ctl_byte[serial_cmd_pkg::CM_BIT] ?
                         S_DATA : S_LOOK;
            end else begin
              state_q <= S_IDLE;
            end
          end else if (wait_q == 16'(serial_cmd_pkg::LOOK_WAIT_CYC - 1)) begin
            state_q <= S_REPLY;
            cnt_q <= 4'h0;
          end else begin
            wait_q <= wait_q + 16'h0001;
          end
        end
        S_DATA: begin
          if (rx_ok) begin
            cnt_q <= cnt_q + 4'h1;
            if (single || cnt_q == 4'(NREG - 1)) begin
              state_q <= S_IDLE;
            end
          end
        end
        default: begin
          state_q <= S_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------
  // parameter bank
  // ----------------------------------------
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < NREG; i++) begin
        param_q[i] <= serial_cmd_pkg::RESET_BYTE;
      end
      param_written <= 1'b0;
    end else begin
      param_written <= 1'b0;
      if (state_q == S_DATA && rx_ok && !is_addr && remote_mode &&
          !tier_hit_q) begin
        if (single) begin
          if (int'(def_q[2:0]) < NREG) begin
            param_q[def_q[2:0]] <= link.ctl_byte;
            param_written <= 1'b1;
          end
        end else begin
          param_q[cnt_q[2:0]] <= link.ctl_byte;
          param_written <= 1'b1;
        end
      end
    end
  end

  for (genvar g = 0; g < NREG; g++) begin : g_out
    assign param_out[g*8 +: 8] = param_q[g];
  end

  // ----------------------------------------
  // reply byte selection
  // ----------------------------------------
  always_comb begin
    tier_byte = serial_cmd_pkg::RESET_BYTE;
    if (tier_q[4:3] == serial_cmd_pkg::FINE_PAGE) begin
      if (tier_q[2:0] == serial_cmd_pkg::FINE_REG && fine_fitted) begin
        tier_byte = {fine_digit, 4'h0};
      end else if (tier_q[2:0] == serial_cmd_pkg::SQL_REG) begin
        tier_byte = {carrier_squelch_flag, 3'h0, squelch_threshold};
      end
    end
  end

  always_comb begin
    tx_byte = serial_cmd_pkg::RESET_BYTE;
    if (cnt_q == 4'h0) begin
      tx_byte = {serial_cmd_pkg::ADDR_CODE, 1'b0, own_address};
    end else if (tier_hit_q) begin
      tx_byte = tier_byte;
    end else if (single) begin
      if (int'(def_q[2:0]) < NREG) begin
        tx_byte = param_q[def_q[2:0]];
      end
    end else if (int'(cnt_q) <= NREG) begin
      tx_byte = param_q[3'(cnt_q - 4'h1)];
    end
  end

  // ----------------------------------------
  // reply driver
  // ----------------------------------------
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      link.rsp_valid <= 1'b0;
      link.rsp_byte <= serial_cmd_pkg::RESET_BYTE;
      link.rsp_par <= 1'b0;
    end else begin
      link.rsp_valid <= state_q == S_REPLY;
      link.rsp_byte <= tx_byte;
      link.rsp_par <= parity_enable &&
        serial_cmd_pkg::par_bit(tx_byte, parity_even);
    end
  end

  // ----------------------------------------
  // chain output port
  // ----------------------------------------
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      chain_valid <= 1'b0;
      chain_byte <= serial_cmd_pkg::RESET_BYTE;
      chain_par <= 1'b0;
    end else begin
      chain_valid <= link.ctl_valid;
      chain_byte <= link.ctl_byte;
      chain_par <= link.ctl_par;
    end
  end
endmodule : chain_receiver_end

/* src/remote_controller_end.sv */
// Local design decision: strobed register access.
`timescale 1ns/1ns
module remote_controller_end #(
  parameter int NREG = serial_cmd_pkg::NUM_PARAMS
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // link to receiver chain
  serial_link_if.controller link,
  // software port
  input wire logic [3:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata
);
  typedef enum logic [2:0] {
    C_IDLE, C_ADDR, C_TIER, C_DEF, C_DATA, C_ECHO, C_RX
  } cstate_t;

  cstate_t state_q;
  logic [3:0] target_q;
  logic [4:0] def_q;
  logic [5:0] tier_q;
  logic [1:0] cfg_q;
  logic [7:0] data_q [NREG];
  logic [3:0] cnt_q;
  logic [15:0] wait_q;
  logic done_q;
  logic err_q;
  logic [7:0] tx_byte;
  logic [7:0] addr_byte;
  logic go;
  logic rsp_ok;
  logic single;
  logic [3:0] last;
  logic finish;
  logic fail;
  logic timeout;
  logic [2:0] rx_idx;

  assign addr_byte = {serial_cmd_pkg::ADDR_CODE, 1'b0, target_q};
  assign go = wr && addr == serial_cmd_pkg::REG_GO && state_q == C_IDLE;
  assign single = def_q[serial_cmd_pkg::SA_BIT];
  assign last = single ? 4'h0 : 4'(NREG - 1);
  assign rsp_ok = link.rsp_valid && (!cfg_q[0] || link.rsp_par ==
    serial_cmd_pkg::par_bit(link.rsp_byte, cfg_q[1]));
  assign timeout = wait_q == 16'(serial_cmd_pkg::RSP_WAIT_CYC - 1);
  assign rx_idx = single ? def_q[2:0] : cnt_q[2:0];

  // ----------------------------------------
  // frame sequencer
  // ----------------------------------------
  always_comb begin
    finish = 1'b0;
    fail = 1'b0;
    case (state_q)
      C_DATA: finish = cnt_q == last;
      C_ECHO: fail = (link.rsp_valid && !(rsp_ok &&
                      link.rsp_byte == addr_byte)) || timeout;
      C_RX: begin
        fail = (link.rsp_valid && !rsp_ok) || timeout;
        finish = rsp_ok && cnt_q == last;
      end
      default: begin
      end
    endcase
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= C_IDLE;
      cnt_q <= 4'h0;
      wait_q <= 16'h0000;
    end else begin
      case (state_q)
        C_IDLE: if (go) begin
          state_q <= C_ADDR;
        end
        C_ADDR: state_q <= tier_q[5] ? C_TIER : C_DEF;
        C_TIER: state_q <= C_DEF;
        C_DEF: begin
          cnt_q <= 4'h0;
          wait_q <= 16'h0000;
          state_q <= def_q[serial_cmd_pkg::CM_BIT] ? C_DATA : C_ECHO;
        end
        C_DATA: begin
          cnt_q <= cnt_q + 4'h1;
          if (finish) begin
            state_q <= C_IDLE;
          end
        end
        C_ECHO: begin
          wait_q <= wait_q + 16'h0001;
          if (fail) begin
            state_q <= C_IDLE;
          end else if (link.rsp_valid) begin
            state_q <= C_RX;
            wait_q <= 16'h0000;
          end
        end
        C_RX: begin
          wait_q <= wait_q + 16'h0001;
          if (fail || finish) begin
            state_q <= C_IDLE;
          end else if (rsp_ok) begin
            cnt_q <= cnt_q + 4'h1;
          end
        end
        default: state_q <= C_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // link driver
  // ----------------------------------------
  always_comb begin
    tx_byte = addr_byte;
    case (state_q)
      C_TIER: tx_byte = {serial_cmd_pkg::DEF_CODE, tier_q[4:0]};
      C_DEF: tx_byte = {serial_cmd_pkg::DEF_CODE,
                        tier_q[5] ? {def_q[4:3], 3'h0} : def_q};
      C_DATA: begin
        tx_byte = serial_cmd_pkg::RESET_BYTE;
        if (int'(rx_idx) < NREG) begin
          tx_byte = data_q[rx_idx];
        end
      end
      default: tx_byte = addr_byte;
    endcase
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      link.ctl_valid <= 1'b0;
      link.ctl_byte <= serial_cmd_pkg::RESET_BYTE;
      link.ctl_par <= 1'b0;
    end else begin
      link.ctl_valid <= state_q inside {C_ADDR, C_TIER, C_DEF, C_DATA};
      link.ctl_byte <= tx_byte;
      link.ctl_par <= cfg_q[0] &&
        serial_cmd_pkg::par_bit(tx_byte, cfg_q[1]);
    end
  end

  // ----------------------------------------
  // software registers
  // ----------------------------------------
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      target_q <= 4'h0;
      def_q <= 5'h00;
      tier_q <= 6'h00;
      cfg_q <= 2'h0;
      for (int i = 0; i < NREG; i++) begin
        data_q[i] <= serial_cmd_pkg::RESET_BYTE;
      end
    end else begin
      if (wr && addr == serial_cmd_pkg::REG_TARGET) begin
        target_q <= wdata[3:0];
      end else if (wr && addr == serial_cmd_pkg::REG_DEF) begin
        def_q <= wdata[4:0];
      end else if (wr && addr == serial_cmd_pkg::REG_TIER) begin
        tier_q <= wdata[5:0];
      end else if (wr && addr == serial_cmd_pkg::REG_CFG) begin
        cfg_q <= wdata[1:0];
      end else if (wr && addr >= serial_cmd_pkg::REG_DATA0 &&
                   addr < serial_cmd_pkg::REG_DATA0 + 4'(NREG)) begin
        data_q[3'(addr - serial_cmd_pkg::REG_DATA0)] <= wdata;
      end
      if (state_q == C_RX && rsp_ok && !fail && int'(rx_idx) < NREG) begin
        data_q[rx_idx] <= link.rsp_byte;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      done_q <= 1'b0;
      err_q <= 1'b0;
    end else begin
      done_q <= (finish && !fail) || (done_q &&
        !(wr && addr == serial_cmd_pkg::REG_STATUS &&
          wdata[serial_cmd_pkg::ST_DONE]));
      err_q <= fail || (err_q &&
        !(wr && addr == serial_cmd_pkg::REG_STATUS &&
          wdata[serial_cmd_pkg::ST_ERR]));
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= 8'h00;
    end else if (!rd) begin
      rdata <= 8'h00;
    end else if (addr == serial_cmd_pkg::REG_TARGET) begin
      rdata <= {4'h0, target_q};
    end else if (addr == serial_cmd_pkg::REG_DEF) begin
      rdata <= {3'h0, def_q};
    end else if (addr == serial_cmd_pkg::REG_TIER) begin
      rdata <= {2'h0, tier_q};
    end else if (addr == serial_cmd_pkg::REG_CFG) begin
      rdata <= {6'h00, cfg_q};
    end else if (addr == serial_cmd_pkg::REG_STATUS) begin
      rdata <= {5'h00, err_q, done_q, state_q != C_IDLE};
    end else if (addr >= serial_cmd_pkg::REG_DATA0 &&
                 addr < serial_cmd_pkg::REG_DATA0 + 4'(NREG)) begin
      rdata <= data_q[3'(addr - serial_cmd_pkg::REG_DATA0)];
    end else begin
      rdata <= 8'h00;
    end
  end
endmodule : remote_controller_end

/* sim/serial_link_asserts.sv */
`timescale 1ns/1ns
module serial_link_asserts (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // controller to device
  input wire logic ctl_valid,
  input wire logic [7:0] ctl_byte,
  input wire logic ctl_par,
  // device to controller
  input wire logic rsp_valid,
  input wire logic [7:0] rsp_byte,
  input wire logic rsp_par
);
  // ----------------------------------------
  // helper state
  // ----------------------------------------
  logic [7:0] last_addr_q;
  logic [6:0] gap_q;
  logic [3:0] run_q;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) last_addr_q <= 8'h00;
    else if (ctl_valid && ctl_byte[7:5] == 3'h6) last_addr_q <= ctl_byte;
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) gap_q <= 7'h00;
    else if (ctl_valid) gap_q <= 7'h00;
    else if (gap_q != 7'h7f) gap_q <= gap_q + 7'h01;
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) run_q <= 4'h0;
    else if (rsp_valid) run_q <= run_q + 4'h1;
    else run_q <= 4'h0;
  end

  default clocking cb_main @(posedge clock); endclocking
  default disable iff (!rst_n);

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  a_frame_starts_addr: assert property (
    $rose(ctl_valid) |-> ctl_byte[7:5] == 3'h6)
    else $error("frame does not open with an address byte");
  a_def_after_addr: assert property (
    ctl_valid && ctl_byte[7:5] == 3'h6 |=>
    ctl_valid && ctl_byte[7:5] == 3'h7)
    else $error("address byte not followed by definition code");
  a_echo_own_addr: assert property (
    $rose(rsp_valid) |-> rsp_byte == last_addr_q)
    else $error("reply does not open with the echoed address");
  a_reply_gap: assert property (
    $rose(rsp_valid) |-> gap_q == 7'd65)
    else $error("reply start not 65 cycles after last request byte");
  a_reply_length: assert property (
    $fell(rsp_valid) |-> run_q == 4'd2 || run_q == 4'd8)
    else $error("reply burst length wrong");
  a_cmd_all_len: assert property (
    ctl_valid && $past(ctl_valid) && $past(ctl_byte[7:5]) == 3'h6 &&
    ctl_byte[7:3] == 5'h1e |=> ctl_valid [*7] ##1 !ctl_valid)
    else $error("all-bytes command not seven data bytes");
  a_cmd_single_len: assert property (
    ctl_valid && $past(ctl_valid) && $past(ctl_byte[7:5]) == 3'h6 &&
    ctl_byte[7:3] == 5'h1f |=> ctl_valid ##1 !ctl_valid)
    else $error("single command not one data byte");
  a_quiet_in_reply: assert property (
    rsp_valid |-> !ctl_valid)
    else $error("controller sent during a reply");
endmodule : serial_link_asserts

/* sim/tb_remote_serial_command_parser.sv */
`timescale 1ns/1ns
module tb_remote_serial_command_parser;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] rdata;
  logic [3:0] own = 4'h5;
  logic remote = 1'b1;
  logic pen = 1'b0;
  logic peven = 1'b0;
  logic fitted = 1'b1;
  logic [8:0] last_c = 9'h000;
  int pw_n = 0;
  int p0;
  logic [55:0] params;
  logic [55:0] exp_p;
  logic pw;
  logic cv;
  logic cp;
  logic [7:0] cb;
  logic [7:0] v;
  int n_mismatch = 0;
  int tests_run = 0;
  int chain_n = 0;
  int c0;

  serial_link_if link ();
  chain_receiver_end chain_receiver_end_i (.clock(clock), .rst_n(rst_n),
    .link(link), .own_address(own), .remote_mode(remote),
    .parity_enable(pen), .parity_even(peven), .fine_fitted(fitted),
    .fine_digit(4'h6), .carrier_squelch_flag(1'b1),
    .squelch_threshold(4'ha), .param_out(params), .param_written(pw),
    .chain_valid(cv), .chain_byte(cb), .chain_par(cp));
  remote_controller_end remote_controller_end_i (.clock(clock),
    .rst_n(rst_n), .link(link), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata));
  serial_link_asserts serial_link_asserts_i (.clock(clock), .rst_n(rst_n),
    .ctl_valid(link.ctl_valid), .ctl_byte(link.ctl_byte),
    .ctl_par(link.ctl_par), .rsp_valid(link.rsp_valid),
    .rsp_byte(link.rsp_byte), .rsp_par(link.rsp_par));

  always @(posedge clock) begin
    if (cv === 1'b1) chain_n <= chain_n + 1;
    if (cv === 1'b1) last_c <= {cp, cb};
    if (pw === 1'b1) pw_n <= pw_n + 1;
  end

  initial begin
    forever #25 clock = ~clock;
  end

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : tally_and_finish

  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
  endtask : wr_reg

  task automatic rd_reg(input logic [3:0] a, output logic [7:0] d);
    @(posedge clock);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    #1 d = rdata;
  endtask : rd_reg

  task automatic load(input logic [55:0] p);
    for (int i = 0; i < 7; i++) begin
      wr_reg(serial_cmd_pkg::REG_DATA0 + 4'(i), p[8*i+:8]);
    end
  endtask : load

  task automatic look(input logic [55:0] p);
    for (int i = 0; i < 7; i++) begin
      rd_reg(serial_cmd_pkg::REG_DATA0 + 4'(i), v);
      check(v, p[8*i+:8]);
    end
  endtask : look

  task automatic run(input logic [3:0] t, input logic [4:0] d,
      input logic [5:0] tr, input logic err);
    int i;
    wr_reg(serial_cmd_pkg::REG_STATUS, 8'h06);
    wr_reg(serial_cmd_pkg::REG_TARGET, {4'h0, t});
    wr_reg(serial_cmd_pkg::REG_DEF, {3'h0, d});
    wr_reg(serial_cmd_pkg::REG_TIER, {2'h0, tr});
    wr_reg(serial_cmd_pkg::REG_GO, 8'h01);
    for (i = 0; i < 700; i++) begin
      rd_reg(serial_cmd_pkg::REG_STATUS, v);
      if (v[serial_cmd_pkg::ST_BUSY] === 1'b0) break;
    end
    if (i == 700) begin
      n_mismatch++;
      tally_and_finish();
    end
    repeat (3) @(posedge clock);
    check(v[serial_cmd_pkg::ST_ERR], err);
    if (!err) check(v[serial_cmd_pkg::ST_DONE], 1'b1);
  endtask : run

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (3) @(posedge clock);
    rst_n <= 1'b1;
    rd_reg(serial_cmd_pkg::REG_STATUS, v);
    check(v, 8'h00);
    check(params, 56'h0);
    rd_reg(4'hd, v);
    check(v, 8'h00);
    for (int k = 0; k < 2; k++) begin
      pen <= 1'b1;
      peven <= k[0];
      wr_reg(serial_cmd_pkg::REG_CFG, {6'h0, k[0], 1'b1});
      exp_p = k[0] ? 56'h0f1e2d3c4b5a69 : 56'ha1b28374659607;
      load(exp_p);
      c0 = chain_n;
      p0 = pw_n;
      run(4'h5, 5'h10, 6'h00, 1'b0);
      check(params, exp_p);
      check(chain_n - c0, 9);
      check(pw_n - p0, 7);
      check(last_c, {(k[0] ? ^exp_p[55:48] : ~^exp_p[55:48]),
                     exp_p[55:48]});
      load(56'h0);
      run(4'h5, 5'h00, 6'h00, 1'b0);
      look(exp_p);
    end
    peven <= 1'b0;
    load(56'h1111111111111);
    run(4'h5, 5'h10, 6'h00, 1'b0);
    check(params, exp_p);
    peven <= 1'b1;
    load({7{8'h5a}});
    run(4'h5, 5'h1b, 6'h00, 1'b0);
    exp_p[31:24] = 8'h5a;
    check(params, exp_p);
    run(4'h5, 5'h1f, 6'h00, 1'b0);
    check(params, exp_p);
    load(56'h0);
    run(4'h5, 5'h0b, 6'h00, 1'b0);
    rd_reg(serial_cmd_pkg::REG_DATA0 + 4'h3, v);
    check(v, 8'h5a);
    remote <= 1'b0;
    load(56'h0);
    run(4'h5, 5'h10, 6'h00, 1'b0);
    check(params, exp_p);
    run(4'h5, 5'h00, 6'h00, 1'b0);
    look(exp_p);
    remote <= 1'b1;
    c0 = chain_n;
    run(4'h9, 5'h10, 6'h00, 1'b0);
    check(params, exp_p);
    check(chain_n - c0, 9);
    run(4'h9, 5'h00, 6'h00, 1'b1);
    run(4'h5, 5'h08, 6'h28, 1'b0);
    rd_reg(serial_cmd_pkg::REG_DATA0, v);
    check(v[7:4], 4'h6);
    run(4'h5, 5'h08, 6'h29, 1'b0);
    rd_reg(serial_cmd_pkg::REG_DATA0, v);
    check(v, 8'h8a);
    fitted <= 1'b0;
    run(4'h5, 5'h08, 6'h28, 1'b0);
    rd_reg(serial_cmd_pkg::REG_DATA0, v);
    check(v, 8'h00);
    tally_and_finish();
  end
endmodule : tb_remote_serial_command_parser
